// File: ule_datapath.sv
// User logic engine execution datapath, system flags and runtime fault reporting.
// Assumes the sequencer issues one operation per cycle and marks sweep bounds.
//
// Operation
// (RULE_01) Program halt posts 91, fast stop
// (RULE_02) Sweep over time limit posts 92, stop
// (RULE_03) Sweep near time limit posts 97 only
// (RULE_04) Zero divisor posts 93, stop, halt
// (RULE_05) Unrepresentable quotient posts 94, stop, halt
// (RULE_06) Add/subtract overflow posts 95, continue
// (RULE_07) Absolute value overflow posts 96, continue
// (RULE_08) First sweep failure posts 98 only
// (RULE_09) Bad program or not enabled posts 99
// (RULE_10) Axis stop error posts 9A, stops axis
// (RULE_11) Narrow destination keeps low bits
// (RULE_12) Signed 32-bit math, 64-bit dividend
// (RULE_13) Sign or zero extend narrow operands
// (RULE_14) Out-of-range motion command discarded, warned
// (RULE_15) First sweep flag high only first sweep
// (RULE_16) Overflow flag set by add/sub/abs overflow
// (RULE_17) Overflow warning posted only while flag set
// (RULE_18) Overflow flag cleared at start, write, toggle
// (RULE_19) Halt bit write stops motion and execution
// (RULE_20) Eight wide and 255 general registers
// (RULE_21) Wide registers only product or dividend
// (RULE_22) Registers keep contents across start
// (RULE_23) Last code held until error clear toggle
`timescale 1ns/1ps
module ule_datapath
  import ulepkg::*;
#(
  parameter int NUM_AXES = 4
) (
  // Clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_nrst,
  // Host register port
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rdata,
  // Sequencer sweep control
  input  wire logic                i_prog_valid,
  input  wire logic                i_sweep_start,
  input  wire logic                i_sweep_end,
  input  wire logic                i_first_fail,
  // Operation issue
  input  wire logic                i_op_valid,
  input  wire logic [3:0]          i_op,
  input  wire logic [31:0]         i_src_a,
  input  wire logic [1:0]          i_size_a,
  input  wire logic                i_sign_a,
  input  wire logic [31:0]         i_src_b,
  input  wire logic [1:0]          i_size_b,
  input  wire logic                i_sign_b,
  input  wire logic                i_a_wide,
  input  wire logic [2:0]          i_wide_idx,
  input  wire logic                i_dst_wide,
  input  wire logic [7:0]          i_dst_idx,
  input  wire logic [1:0]          i_dst_size,
  // Program writes of system variables and motion commands
  input  wire logic                i_ovf_wr,
  input  wire logic                i_ovf_wval,
  input  wire logic                i_halt_wr,
  input  wire logic                i_halt_wval,
  input  wire logic                i_cmd_wr,
  input  wire logic [31:0]         i_cmd_val,
  input  wire logic [31:0]         i_cmd_min,
  input  wire logic [31:0]         i_cmd_max,
  // Motion side
  input  wire logic [NUM_AXES-1:0] i_axis_stop_err,
  output logic      [NUM_AXES-1:0] o_axis_fast_stop,
  output logic                     o_fast_stop,
  output logic                     o_cmd_strobe,
  output logic      [31:0]         o_cmd_word,
  // Results and flags
  output logic      [31:0]         o_result,
  output logic                     o_first_sweep,
  output logic                     o_overflow,
  output logic                     o_running
);

  typedef enum logic [2:0] {
    ULE_IDLE = 3'b001,
    ULE_RUN  = 3'b010,
    ULE_HALT = 3'b100
  } ule_state_type;

  typedef struct packed {
    ule_state_type         state;
    logic [31:0]           ctrl;
    logic [31:0]           limit;
    logic [31:0]           warn;
    logic                  clr_prev;
    logic [7:0]            code;
    logic                  first;
    logic                  first_pending;
    logic                  ovf;
    logic [31:0]           cyc;
    logic                  warned;
    logic                  fstop;
    logic [NUM_AXES-1:0]   axis_stop;
    logic [31:0]           result;
    logic [31:0]           rdata;
    logic                  cmd_strobe;
    logic [31:0]           cmd_word;
  } ule_regs_type;

  ule_regs_type r;
  ule_regs_type next_r;

  // Register arrays are left without reset so contents persist
  logic [63:0] wide_product_regs  [NUM_WIDE];  // RULE_20
  logic [31:0] general_param_regs [NUM_PARAM]; // RULE_20

  logic signed [31:0] a_ext;
  logic signed [31:0] b_ext;
  logic signed [63:0] dividend;
  logic signed [63:0] product;
  logic signed [63:0] quot;
  logic signed [63:0] remd;
  logic signed [32:0] sum33;
  logic [31:0]        alu;
  logic [31:0]        stored;
  logic               add_ovf;
  logic               abs_ovf;
  logic               div_zero;
  logic               div_ovf;
  logic               wr_wide;
  logic               wr_param;

  function automatic logic [31:0] ule_extend(input logic [31:0] v, input logic [1:0] sz,
                                             input logic sgn);
    logic [31:0] res;
    res = v;
    unique case (sz)
      SZ_BIT: res = {31'h0, v[0]};
      SZ_8:   res = sgn ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]};
      SZ_16:  res = sgn ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
      SZ_32:  res = v;
    endcase
    return res;
  endfunction

  always_comb begin
    a_ext    = ule_extend(i_src_a, i_size_a, i_sign_a);  // RULE_13
    b_ext    = ule_extend(i_src_b, i_size_b, i_sign_b);  // RULE_13
    // Only divide and modulus take a wide operand, as dividend
    dividend = i_a_wide ? wide_product_regs[i_wide_idx] : 64'(a_ext); // RULE_21
    product  = 64'(a_ext) * 64'(b_ext);                               // RULE_12
    div_zero = (b_ext == 32'sh0000_0000);
    quot     = div_zero ? 64'sh0 : dividend / 64'(b_ext);             // RULE_12
    remd     = div_zero ? 64'sh0 : dividend % 64'(b_ext);
    // The quotient fits only if it survives a trip through 32 signed bits
    div_ovf  = !div_zero && (quot != 64'($signed(quot[31:0])));      // RULE_05
    sum33    = (i_op == OP_SUB) ? 33'(a_ext) - 33'(b_ext) : 33'(a_ext) + 33'(b_ext);
    add_ovf  = (i_op == OP_ADD || i_op == OP_SUB) && (sum33[32] != sum33[31]);
    abs_ovf  = (i_op == OP_ABS) && (a_ext == 32'sh8000_0000);
    alu      = 32'h0000_0000;
    unique case (i_op)
      OP_ADD, OP_SUB: alu = sum33[31:0];
      OP_MUL:         alu = product[31:0];
      OP_DIV:         alu = quot[31:0];
      OP_MOD:         alu = remd[31:0];
      OP_ABS:         alu = a_ext[31] ? 32'(-a_ext) : a_ext;
      OP_AND:         alu = a_ext & b_ext;
      OP_OR:          alu = a_ext | b_ext;
      OP_XOR:         alu = a_ext ^ b_ext;
      default:        alu = 32'h0000_0000;
    endcase
    stored = alu;
    unique case (i_dst_size)
      SZ_BIT: stored = {31'h0, alu[0]};   // RULE_11
      SZ_8:   stored = {24'h0, alu[7:0]}; // RULE_11
      SZ_16:  stored = {16'h0, alu[15:0]}; // RULE_11
      SZ_32:  stored = alu;
    endcase
  end

  assign wr_wide  = i_op_valid && (r.state == ULE_RUN) && i_dst_wide && (i_op == OP_MUL);
  // Index 0 and a failed divide leave the general registers alone
  assign wr_param = i_op_valid && (r.state == ULE_RUN) && !i_dst_wide
                    && !((i_op == OP_DIV || i_op == OP_MOD) && (div_zero || div_ovf))
                    && (i_dst_idx != 8'h00);

  // Program writes only; start does not touch contents
  always_ff @(posedge i_clk_sys) begin
    if (wr_wide) begin
      wide_product_regs[i_dst_idx[2:0]] <= product; // RULE_21
    end
    if (wr_param) begin
      general_param_regs[i_dst_idx] <= stored;     // RULE_22
    end
  end

  always_comb begin
    logic clr_tog;
    logic run_req;
    logic [7:0] post;
    logic stop;
    clr_tog = 1'b0;
    run_req = 1'b0;
    post    = CODE_NONE;
    stop    = 1'b0;
    next_r  = r;
    next_r.cmd_strobe = 1'b0;
    next_r.rdata      = 32'h0000_0000;
    if (i_wr) begin
      unique case (i_addr)
        ADDR_CTRL:  next_r.ctrl  = i_wdata;
        ADDR_LIMIT: next_r.limit = i_wdata;
        ADDR_WARN:  next_r.warn  = i_wdata;
        default:    ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CTRL:   next_r.rdata = r.ctrl;
        // Axis stops in the high nibble above the four flags
        ADDR_STATUS: next_r.rdata = {24'h0, 4'(r.axis_stop), r.ovf, r.first, r.fstop,
                                     r.state == ULE_RUN};
        ADDR_CODE:   next_r.rdata = {24'h0, r.code};
        ADDR_LIMIT:  next_r.rdata = r.limit;
        ADDR_WARN:   next_r.rdata = r.warn;
        default:     next_r.rdata = 32'h0000_0000;
      endcase
    end
    clr_tog       = r.ctrl[CTRL_CLR_BIT] != r.clr_prev;
    next_r.clr_prev = r.ctrl[CTRL_CLR_BIT];
    run_req       = r.ctrl[CTRL_RUN_BIT] && r.ctrl[CTRL_ENCFG_BIT];
    // Clear first, so that an event in the same cycle sets its flag again
    if (clr_tog) begin
      next_r.code  = CODE_NONE;        // RULE_23
      next_r.ovf   = 1'b0;             // RULE_18
      next_r.fstop = 1'b0;
    end
    unique case (r.state)
      ULE_IDLE: begin
        if (run_req && i_prog_valid) begin
          next_r.state         = ULE_RUN;
          next_r.ovf           = 1'b0;  // RULE_18
          next_r.first_pending = 1'b1;  // RULE_15
          next_r.cyc           = 32'h0000_0000;
        end else if (r.ctrl[CTRL_RUN_BIT] && (!i_prog_valid || !r.ctrl[CTRL_ENCFG_BIT])) begin
          post = CODE_NOT_EN;           // RULE_09
        end
      end
      ULE_RUN: begin
        if (!run_req) begin
          next_r.state = ULE_IDLE;
          next_r.first = 1'b0;
        end
        if (i_sweep_start) begin
          next_r.first         = r.first_pending; // RULE_15
          next_r.first_pending = 1'b0;
          next_r.cyc           = 32'h0000_0000;
          next_r.warned        = 1'b0;
        end else begin
          next_r.cyc = r.cyc + 32'h0000_0001;
        end
        // The limit check wins over the warning in the same cycle
        if (r.cyc >= r.limit) begin
          post = CODE_TIME_OVER;       // RULE_02
          stop = 1'b1;
        end else if (r.cyc >= r.warn && !r.warned) begin
          post          = CODE_TIME_WARN; // RULE_03
          next_r.warned = 1'b1;
        end
        if (i_first_fail && r.first) begin
          post = CODE_FIRST_ERR;       // RULE_08
        end
        if (i_op_valid && (i_op == OP_DIV || i_op == OP_MOD)) begin
          if (div_zero) begin
            post = CODE_DIV_ZERO;      // RULE_04
            stop = 1'b1;
          end else if (div_ovf) begin
            post = CODE_DIV_OVF;       // RULE_05
            stop = 1'b1;
          end
        end
        if (i_ovf_wr) begin
          next_r.ovf = i_ovf_wval;     // RULE_18
        end
        if (i_op_valid && (add_ovf || abs_ovf)) begin
          next_r.ovf = 1'b1;           // RULE_16
        end
        // Warn again at sweep end unless the program writes the flag now
        if (i_sweep_end && r.ovf && !i_ovf_wr) begin
          post = CODE_ADD_OVF;         // RULE_17
        end
        if (i_op_valid && add_ovf && !(i_sweep_end && i_ovf_wr && !i_ovf_wval)) begin
          post = CODE_ADD_OVF;         // RULE_06
        end
        if (i_op_valid && abs_ovf) begin
          post = CODE_ABS_OVF;         // RULE_07
        end
        // A rejected value leaves the last good command word standing
        if (i_cmd_wr) begin
          if ($signed(i_cmd_val) < $signed(i_cmd_min) ||
              $signed(i_cmd_val) > $signed(i_cmd_max)) begin
            post = CODE_CMD_RANGE;     // RULE_14
          end else begin
            next_r.cmd_strobe = 1'b1;
            next_r.cmd_word   = i_cmd_val;
          end
        end
        if (i_halt_wr && i_halt_wval) begin
          post = CODE_HALT;            // RULE_01 RULE_19
          stop = 1'b1;
        end
        if (stop) begin
          next_r.state = ULE_HALT;     // RULE_04 RULE_05 RULE_19
          next_r.fstop = 1'b1;         // RULE_01 RULE_02
          next_r.first = 1'b0;
        end
        if (i_op_valid && !stop) begin
          next_r.result = stored;
        end
      end
      ULE_HALT: begin
        // Stays halted until the host drops run
        if (!run_req) begin
          next_r.state = ULE_IDLE;
        end
      end
      default: next_r.state = ULE_IDLE;
    endcase
    if (|i_axis_stop_err) begin
      post = CODE_STOP_ERR;            // RULE_10
    end
    next_r.axis_stop = (clr_tog ? {NUM_AXES{1'b0}} : r.axis_stop) | i_axis_stop_err; // RULE_10
    // A new event wins over a same-cycle clear
    if (post != CODE_NONE) begin
      next_r.code = post;              // RULE_23
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '{state:         ULE_IDLE,
             ctrl:          32'h0000_0000,
             limit:         LIMIT_RESET,
             warn:          WARN_RESET,
             clr_prev:      1'b0,
             code:          CODE_NONE,
             first:         1'b0,
             first_pending: 1'b0,
             ovf:           1'b0,
             cyc:           32'h0000_0000,
             warned:        1'b0,
             fstop:         1'b0,
             axis_stop:     '0,
             result:        32'h0000_0000,
             rdata:         32'h0000_0000,
             cmd_strobe:    1'b0,
             cmd_word:      32'h0000_0000};
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata          = r.rdata;
  assign o_result         = r.result;
  assign o_first_sweep    = r.first;
  assign o_overflow       = r.ovf;
  assign o_running        = (r.state == ULE_RUN);
  assign o_fast_stop      = r.fstop;
  assign o_axis_fast_stop = r.axis_stop | {NUM_AXES{r.fstop}};
  assign o_cmd_strobe     = r.cmd_strobe;
  assign o_cmd_word       = r.cmd_word;

endmodule

// File: ulepkg.sv
// Shared constants of the user logic engine datapath and fault block.
// Assumes a single 250 MHz system clock; no bus beyond the plain register port.
package ulepkg;
  // Runtime codes posted to the module status
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_HALT      = 8'h91;
  localparam logic [7:0] CODE_TIME_OVER = 8'h92;
  localparam logic [7:0] CODE_DIV_ZERO  = 8'h93;
  localparam logic [7:0] CODE_DIV_OVF   = 8'h94;
  localparam logic [7:0] CODE_ADD_OVF   = 8'h95;
  localparam logic [7:0] CODE_ABS_OVF   = 8'h96;
  localparam logic [7:0] CODE_TIME_WARN = 8'h97;
  localparam logic [7:0] CODE_FIRST_ERR = 8'h98;
  localparam logic [7:0] CODE_NOT_EN    = 8'h99;
  localparam logic [7:0] CODE_STOP_ERR  = 8'h9A;
  localparam logic [7:0] CODE_CMD_RANGE = 8'h9B;
  // Operations
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_MUL = 4'h2;
  localparam logic [3:0] OP_DIV = 4'h3;
  localparam logic [3:0] OP_MOD = 4'h4;
  localparam logic [3:0] OP_ABS = 4'h5;
  localparam logic [3:0] OP_AND = 4'h6;
  localparam logic [3:0] OP_OR  = 4'h7;
  localparam logic [3:0] OP_XOR = 4'h8;
  // Operand and destination sizes
  localparam logic [1:0] SZ_BIT = 2'h0;
  localparam logic [1:0] SZ_8   = 2'h1;
  localparam logic [1:0] SZ_16  = 2'h2;
  localparam logic [1:0] SZ_32  = 2'h3;
  // Register port map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CODE   = 8'h08;
  localparam logic [7:0] ADDR_LIMIT  = 8'h0C;
  localparam logic [7:0] ADDR_WARN   = 8'h10;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam int CTRL_ENCFG_BIT = 2;
  // Sweep time limit defaults in cycles
  localparam logic [31:0] LIMIT_RESET = 32'h0000_2710;
  localparam logic [31:0] WARN_RESET  = 32'h0000_1F40;
  localparam int NUM_WIDE  = 8;
  localparam int NUM_PARAM = 256;
endpackage

// File: ule_checker.sv
// Port checker for ule_datapath.
// Bound to every ule_datapath instance; sees only its ports.
`timescale 1ns/1ps
module ule_checker
  import ulepkg::*;
#(
  parameter int NUM_AXES = 4
) (
  input wire logic                i_clk_sys,
  input wire logic                i_nrst,
  input wire logic                i_rd,
  input wire logic                i_sweep_start,
  input wire logic                i_op_valid,
  input wire logic [3:0]          i_op,
  input wire logic [31:0]         i_src_a,
  input wire logic [1:0]          i_size_a,
  input wire logic [31:0]         i_src_b,
  input wire logic [1:0]          i_size_b,
  input wire logic                i_ovf_wr,
  input wire logic                i_ovf_wval,
  input wire logic                i_halt_wr,
  input wire logic                i_halt_wval,
  input wire logic                i_cmd_wr,
  input wire logic [31:0]         i_cmd_val,
  input wire logic [31:0]         i_cmd_min,
  input wire logic [31:0]         i_cmd_max,
  input wire logic [NUM_AXES-1:0] i_axis_stop_err,
  input wire logic [NUM_AXES-1:0] o_axis_fast_stop,
  input wire logic                o_fast_stop,
  input wire logic                o_cmd_strobe,
  input wire logic [31:0]         o_rdata,
  input wire logic                o_first_sweep,
  input wire logic                o_overflow,
  input wire logic                o_running
);
  logic [31:0] sum;
  assign sum = i_src_a + i_src_b;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  rdata_idle_a: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000) else $error("read data not zero");
  div_zero_a: assert property (
    o_running && i_op_valid && i_op == OP_DIV && i_src_b == 32'h0000_0000
    |=> o_fast_stop && !o_running) else $error("zero divisor did not stop");
  add_ovf_a: assert property (
    o_running && i_op_valid && i_op == OP_ADD && !i_ovf_wr && i_size_a == SZ_32
    && i_size_b == SZ_32 && i_src_a[31] == i_src_b[31] && sum[31] != i_src_a[31]
    |=> o_overflow) else $error("add overflow flag not set");
  first_drop_a: assert property (
    o_first_sweep && i_sweep_start |=> !o_first_sweep) else $error("first sweep stayed");
  halt_stop_a: assert property (
    o_running && i_halt_wr && i_halt_wval |=> o_fast_stop && !o_running)
    else $error("halt write did not stop");
  ovf_clear_a: assert property (
    o_running && i_ovf_wr && !i_ovf_wval && !i_op_valid |=> !o_overflow)
    else $error("overflow write of zero ignored");
  axis_stop_a: assert property (
    o_running && i_axis_stop_err != '0
    |=> (o_axis_fast_stop & $past(i_axis_stop_err)) == $past(i_axis_stop_err))
    else $error("axis stop not raised");
  cmd_reject_a: assert property (
    o_running && i_cmd_wr && ($signed(i_cmd_val) < $signed(i_cmd_min)
    || $signed(i_cmd_val) > $signed(i_cmd_max)) |=> !o_cmd_strobe)
    else $error("out of range command passed");
endmodule

bind ule_datapath ule_checker #(.NUM_AXES(NUM_AXES)) u_chk (.*);

// File: ule_servo_model.sv
// Servo side model: raises a one-cycle stop error on one axis on request.
// Shares the datapath clock.
`timescale 1ns/1ps
module ule_servo_model #(
  parameter int NUM_AXES = 4
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_trip,
  input  wire logic [1:0]          i_axis,
  input  wire logic [NUM_AXES-1:0] i_fast_stop,
  output logic      [NUM_AXES-1:0] o_stop_err
);
  // An axis already stopped reports no new error
  always @(posedge i_clk_sys) begin
    o_stop_err <= i_trip ? (NUM_AXES'(1) << i_axis) & ~i_fast_stop : '0;
  end
endmodule

// File: test_ule_datapath.sv
// Testbench for ule_datapath with a servo side model.
// Drives the register port and the sequencer inputs directly.
`timescale 1ns/1ps
module test_ule_datapath
  import ulepkg::*;
;
  logic i_clk_sys = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_prog_valid = 0, i_sweep_start = 0;
  logic i_sweep_end = 0, i_first_fail = 0, i_op_valid = 0, i_sign_a = 1, i_sign_b = 1;
  logic i_a_wide = 0, i_dst_wide = 0, i_ovf_wr = 0, i_ovf_wval = 0, i_halt_wr = 0;
  logic i_halt_wval = 1, i_cmd_wr = 0, trip = 0, clr = 0;
  logic [7:0]  i_addr = 0, i_dst_idx = 1;
  logic [3:0]  i_op = 0;
  logic [2:0]  i_wide_idx = 3;
  logic [1:0]  i_size_a = SZ_32, i_size_b = SZ_32, i_dst_size = SZ_32;
  logic [31:0] i_wdata = 0, i_src_a = 0, i_src_b = 0, i_cmd_val = 0;
  logic [31:0] i_cmd_min = 0, i_cmd_max = 32'h0000_000A, o_rdata, o_result, o_cmd_word;
  logic [3:0]  i_axis_stop_err, o_axis_fast_stop;
  logic        o_fast_stop, o_cmd_strobe, o_first_sweep, o_overflow, o_running;
  int          fails = 0, checked = 0, cyc = 0;

  ule_datapath #(.NUM_AXES(4)) dut (.*);
  ule_servo_model #(.NUM_AXES(4)) servo (.i_clk_sys(i_clk_sys), .i_trip(trip),
    .i_axis(2'h1), .i_fast_stop(o_axis_fast_stop), .o_stop_err(i_axis_stop_err));

  always #2 i_clk_sys = ~i_clk_sys;

  task automatic print_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys) i_wr <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys) i_rd <= 0;
    #1 chk(o_rdata & m, exp);
  endtask

  task automatic op(input logic [3:0] o, input logic [31:0] a, input logic [31:0] b,
                    input logic [1:0] sz, input logic [1:0] ds, input logic [31:0] exp,
                    input bit ck);
    @(posedge i_clk_sys) begin
      {i_op_valid, i_op, i_src_a, i_src_b} <= {1'b1, o, a, b};
      {i_size_a, i_dst_size} <= {sz, ds};
    end
    @(posedge i_clk_sys) i_op_valid <= 0;
    #1 if (ck) chk(o_result, exp);
  endtask

  task automatic cmd(input logic [31:0] v, input logic ok);
    @(posedge i_clk_sys) {i_cmd_wr, i_cmd_val} <= {1'b1, v};
    @(posedge i_clk_sys) i_cmd_wr <= 0;
    #1 chk(o_cmd_strobe, ok);
    if (ok) chk(o_cmd_word, v);
  endtask

  task automatic restart;
    clr = ~clr;
    wr(ADDR_CTRL, {29'h0, 1'b1, clr, 1'b0});
    wr(ADDR_CTRL, {29'h0, 1'b1, clr, 1'b1});
    repeat (2) @(posedge i_clk_sys);
    @(posedge i_clk_sys) i_sweep_start <= 1;
    @(posedge i_clk_sys) i_sweep_start <= 0;
  endtask

  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1;
    rd(ADDR_CODE, '1, 0);
    rd(ADDR_LIMIT, '1, LIMIT_RESET);
    rd(ADDR_WARN, '1, WARN_RESET);
    rd(8'h40, '1, 0);
    wr(ADDR_CTRL, 32'h0000_0005);
    repeat (3) @(posedge i_clk_sys);
    rd(ADDR_CODE, '1, CODE_NOT_EN);
    @(posedge i_clk_sys) i_prog_valid <= 1;
    restart;
    #1 chk(o_first_sweep, 1);
    op(OP_ADD, 32'h7FFF_FFFF, 1, SZ_32, SZ_32, 32'h8000_0000, 1);
    chk(o_overflow, 1);
    rd(ADDR_CODE, '1, CODE_ADD_OVF);
    @(posedge i_clk_sys) i_ovf_wr <= 1;
    @(posedge i_clk_sys) i_ovf_wr <= 0;
    #1 chk(o_overflow, 0);
    op(OP_SUB, 32'h8000_0000, 1, SZ_32, SZ_32, 32'h7FFF_FFFF, 1);
    chk(o_overflow, 1);
    op(OP_ABS, 32'h8000_0000, 0, SZ_32, SZ_32, 0, 0);
    rd(ADDR_CODE, '1, CODE_ABS_OVF);
    op(OP_ADD, 32'h80, 0, SZ_8, SZ_32, 32'hFFFF_FF80, 1);
    @(posedge i_clk_sys) i_sign_a <= 0;
    op(OP_ADD, 32'h8000, 0, SZ_16, SZ_32, 32'h0000_8000, 1);
    @(posedge i_clk_sys) i_sign_a <= 1;
    op(OP_ADD, 32'hFF, 0, SZ_BIT, SZ_32, 1, 1);
    op(OP_ADD, 32'h1234_5678, 0, SZ_32, SZ_16, 32'h0000_5678, 1);
    op(OP_AND, 32'hF0F0, 32'hFF00, SZ_32, SZ_32, 32'h0000_F000, 1);
    op(OP_OR, 32'hF0F0, 32'hFF00, SZ_32, SZ_32, 32'h0000_FFF0, 1);
    op(OP_XOR, 32'hF0F0, 32'hFF00, SZ_32, SZ_32, 32'h0000_0FF0, 1);
    @(posedge i_clk_sys) {i_dst_wide, i_dst_idx} <= {1'b1, 8'h03};
    op(OP_MUL, 32'h0001_0000, 32'h0001_0000, SZ_32, SZ_32, 0, 0);
    @(posedge i_clk_sys) {i_dst_wide, i_a_wide} <= 2'b01;
    op(OP_DIV, 0, 4, SZ_32, SZ_32, 32'h4000_0000, 1);
    op(OP_MOD, 0, 7, SZ_32, SZ_32, 4, 1);
    @(posedge i_clk_sys) i_sweep_end <= 1;
    @(posedge i_clk_sys) {i_sweep_end, i_sweep_start} <= 2'b01;
    @(posedge i_clk_sys) i_sweep_start <= 0;
    #1 chk(o_first_sweep, 0);
    rd(ADDR_CODE, '1, CODE_ADD_OVF);
    cmd(32'h0000_000A, 1);
    cmd(32'hFFFF_FFFF, 0);
    cmd(32'h0000_000B, 0);
    rd(ADDR_CODE, '1, CODE_CMD_RANGE);
    @(posedge i_clk_sys) trip <= 1;
    @(posedge i_clk_sys) trip <= 0;
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_axis_fast_stop, 4'h2);
    rd(ADDR_CODE, '1, CODE_STOP_ERR);
    rd(ADDR_STATUS, 32'h0000_00F0, 32'h0000_0020);
    restart;
    rd(ADDR_CODE, '1, 0);
    chk({o_axis_fast_stop, o_overflow, o_running}, 6'h01);
    op(OP_DIV, 0, 1, SZ_32, SZ_32, 0, 0);
    rd(ADDR_CODE, '1, CODE_DIV_OVF);
    chk({o_fast_stop, o_running}, 2'b10);
    restart;
    i_a_wide <= 0;
    op(OP_DIV, 5, 0, SZ_32, SZ_32, 0, 0);
    rd(ADDR_CODE, '1, CODE_DIV_ZERO);
    restart;
    @(posedge i_clk_sys) i_halt_wr <= 1;
    @(posedge i_clk_sys) i_halt_wr <= 0;
    rd(ADDR_CODE, '1, CODE_HALT);
    chk({o_fast_stop, o_running}, 2'b10);
    restart;
    @(posedge i_clk_sys) i_first_fail <= 1;
    @(posedge i_clk_sys) i_first_fail <= 0;
    rd(ADDR_CODE, '1, CODE_FIRST_ERR);
    chk({o_fast_stop, o_running}, 2'b01);
    wr(ADDR_LIMIT, 32'h0000_0028);
    wr(ADDR_WARN, 32'h0000_0014);
    restart;
    repeat (25) @(posedge i_clk_sys);
    rd(ADDR_CODE, '1, CODE_TIME_WARN);
    chk({o_fast_stop, o_running}, 2'b01);
    repeat (20) @(posedge i_clk_sys);
    rd(ADDR_STATUS, 32'h0000_0003, 32'h0000_0002);
    rd(ADDR_CODE, '1, CODE_TIME_OVER);
    print_verdict;
  end
endmodule
